// [rtl/hps_pkg.sv]
// Package of offsets, sizes and reset values for the hub string registers
package hps_pkg;
  localparam logic [7:0] HPS_OFS_RESTRICT = 8'h26;
  localparam logic [7:0] HPS_OFS_SERIAL = 8'h30;
  localparam logic [7:0] HPS_OFS_MAKER = 8'h50;
  localparam logic [7:0] HPS_OFS_PRODUCT = 8'h90;
  localparam int HPS_SERIAL_BYTES = 32;
  localparam int HPS_TEXT_BYTES = 64;
  localparam logic [6:0] HPS_MAX_LEN = 7'h40;
  localparam logic [6:0] HPS_SERIAL_LEN = 7'h20;
  localparam logic [3:0] HPS_RESTRICT_RST = 4'h0;
  localparam logic [7:0] HPS_TEXT_RST = 8'h00;
  localparam logic [7:0] HPS_IDX_SERIAL = 8'h01;
  localparam logic [7:0] HPS_IDX_PRODUCT = 8'h02;
  localparam logic [7:0] HPS_IDX_MAKER = 8'h03;

  typedef enum logic [1:0]
  {
    HPS_SRC_NONE = 2'b00,
    HPS_SRC_SERIAL = 2'b01,
    HPS_SRC_PRODUCT = 2'b10,
    HPS_SRC_MAKER = 2'b11
  } hps_src_t;

  // Lengths above the array size are cut to the array size
  function automatic logic [6:0] hps_clamp_len(input logic [6:0] len);
    hps_clamp_len = (len > HPS_MAX_LEN) ? HPS_MAX_LEN : len;
  endfunction
endpackage

// [rtl/hps_string_select.sv]
// String descriptor index decode: picks the source array and its length
`timescale 1ns/100ps
module hps_string_select
  import hps_pkg::*;
(
  input wire logic [7:0] desc_index,
  input wire logic [6:0] maker_string_length,
  input wire logic [6:0] product_text_length,
  output hps_src_t src,
  output logic [6:0] str_len
);
  wire logic [6:0] maker_len;
  wire logic [6:0] product_len;
  wire logic is_serial;
  wire logic is_product;
  wire logic is_maker;

  assign maker_len = hps_clamp_len(maker_string_length);
  assign product_len = hps_clamp_len(product_text_length);
  assign is_serial = (desc_index == HPS_IDX_SERIAL);
  // Zero length means the string is not provided
  assign is_product = (desc_index == HPS_IDX_PRODUCT) &&
                      (product_len != 7'h00);
  assign is_maker = (desc_index == HPS_IDX_MAKER) && (maker_len != 7'h00);

  assign src = is_serial ? HPS_SRC_SERIAL :
               is_product ? HPS_SRC_PRODUCT :
               is_maker ? HPS_SRC_MAKER : HPS_SRC_NONE;
  assign str_len = is_serial ? HPS_SERIAL_LEN :
                   is_product ? product_len :
                   is_maker ? maker_len : 7'h00;
endmodule

// [rtl/hps_regs.sv]
// Port restriction and string byte registers of the hub
//
// Function
// - Bits 7:4 of the port restriction register are read only and read 0.
// - A restriction bit of 0 allows USB 3.1 and 2.0, a 1 allows only 2.0.
// - Serial bytes form the string descriptor at index 1.
// - Serial bytes are writable only while custom serial enable is 1.
// - A nonzero maker length answers index 3 with that many maker bytes.
// - A nonzero product length answers index 2 with that many bytes.
// - Length zero means no string and lengths are capped at 64 bytes.
`timescale 1ns/100ps
module hps_regs
  import hps_pkg::*;
#(
  parameter logic [7:0] SERIAL_DEFAULT = 8'h00 // Arbitrary value
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic removable_override_enable,
  input wire logic custom_serial_enable,
  input wire logic custom_strings_enable,
  input wire logic [6:0] maker_string_length,
  input wire logic [6:0] product_text_length,
  input wire logic [3:0] port_available,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic desc_req,
  input wire logic [7:0] desc_index,
  input wire logic [6:0] desc_pos,
  output logic desc_ack,
  output logic desc_hit,
  output logic [6:0] desc_len,
  output logic [7:0] desc_data,
  output logic [3:0] port_usb3_enable,
  output logic [3:0] port_usb2_enable
);
  logic [3:0] port_usb2_restrict_ff;
  logic [7:0] serial_id_byte_ff [HPS_SERIAL_BYTES];
  logic [7:0] maker_text_byte_ff [HPS_TEXT_BYTES];
  logic [7:0] product_text_byte_ff [HPS_TEXT_BYTES];
  logic [7:0] reg_rdata_ff;
  logic reg_rd_valid_ff;
  logic desc_ack_ff;
  logic desc_hit_ff;
  logic [6:0] desc_len_ff;
  logic [7:0] desc_data_ff;
  logic [3:0] port_usb3_enable_ff;
  logic [3:0] port_usb2_enable_ff;

  hps_src_t src;
  logic [6:0] str_len;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  // One past the last product byte; higher addresses are unmapped
  localparam logic [7:0] PRODUCT_END = HPS_OFS_PRODUCT + 8'(HPS_TEXT_BYTES);
  // Offsets wrap below each base, so the hit wires must qualify them
  wire logic [7:0] serial_off = reg_addr - HPS_OFS_SERIAL;
  wire logic [7:0] maker_off = reg_addr - HPS_OFS_MAKER;
  wire logic [7:0] product_off = reg_addr - HPS_OFS_PRODUCT;
  wire logic hit_restrict = (reg_addr == HPS_OFS_RESTRICT);
  wire logic hit_serial = (reg_addr >= HPS_OFS_SERIAL) &&
                          (reg_addr < HPS_OFS_MAKER);
  wire logic hit_maker = (reg_addr >= HPS_OFS_MAKER) &&
                         (reg_addr < HPS_OFS_PRODUCT);
  wire logic hit_product = (reg_addr >= HPS_OFS_PRODUCT) &&
                           (reg_addr < PRODUCT_END);
  wire logic [4:0] serial_sel = serial_off[4:0];
  wire logic [5:0] maker_sel = maker_off[5:0];
  wire logic [5:0] product_sel = product_off[5:0];

  // Writes without the matching enable are dropped silently
  wire logic wr_restrict = reg_wr && hit_restrict &&
                           removable_override_enable;
  wire logic wr_serial = reg_wr && hit_serial &&
                         custom_serial_enable;
  wire logic wr_maker = reg_wr && hit_maker && custom_strings_enable;
  wire logic wr_product = reg_wr && hit_product && custom_strings_enable;

  wire logic [7:0] rd_mux =
    hit_restrict ? {4'h0, port_usb2_restrict_ff} :
    hit_serial ? serial_id_byte_ff[serial_sel] :
    hit_maker ? maker_text_byte_ff[maker_sel] :
    hit_product ? product_text_byte_ff[product_sel] : 8'h00;

  // ***********************************************************
  // Descriptor byte fetch
  // ***********************************************************
  hps_string_select u_select
  (
    .desc_index(desc_index),
    .maker_string_length(maker_string_length),
    .product_text_length(product_text_length),
    .src(src),
    .str_len(str_len)
  );

  // Bytes past the length read as zero, never stale array content
  wire logic pos_in = (desc_pos < str_len);
  wire logic [7:0] desc_mux =
    !pos_in ? 8'h00 :
    (src == HPS_SRC_SERIAL) ? serial_id_byte_ff[desc_pos[4:0]] :
    (src == HPS_SRC_PRODUCT) ? product_text_byte_ff[desc_pos[5:0]] :
    (src == HPS_SRC_MAKER) ? maker_text_byte_ff[desc_pos[5:0]] :
    8'h00;

  // Enables follow their inputs one cycle late, like every other output
  // Restriction wins over availability for each port
  wire logic [3:0] nxt_usb3 = port_available & ~port_usb2_restrict_ff;
  wire logic [3:0] nxt_usb2 = port_available | port_usb2_restrict_ff;

  // ***********************************************************
  // Storage
  // ***********************************************************
  // Reset acts even while the clock enable is low
  always_ff @(posedge core_clk)
  begin
    if (reset)
      port_usb2_restrict_ff <= HPS_RESTRICT_RST;
    else if (clk_en && wr_restrict)
      port_usb2_restrict_ff <= reg_wdata[3:0];
  end

  // Serial default stands in for a factory value
  always_ff @(posedge core_clk)
  begin
    if (reset)
      serial_id_byte_ff <= '{default: SERIAL_DEFAULT};
    else if (clk_en && wr_serial)
      serial_id_byte_ff[serial_sel] <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      maker_text_byte_ff <= '{default: HPS_TEXT_RST};
    else if (clk_en && wr_maker)
      maker_text_byte_ff[maker_sel] <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      product_text_byte_ff <= '{default: HPS_TEXT_RST};
    else if (clk_en && wr_product)
      product_text_byte_ff[product_sel] <= reg_wdata;
  end

  // ***********************************************************
  // Registered answers
  // ***********************************************************
  // Read data holds until the next read; valid follows the read strobe one cycle late
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      reg_rdata_ff <= 8'h00;
      reg_rd_valid_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rd_valid_ff <= reg_rd;
      if (reg_rd)
        reg_rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      desc_ack_ff <= 1'b0;
      desc_hit_ff <= 1'b0;
      desc_len_ff <= 7'h00;
      desc_data_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      desc_ack_ff <= desc_req;
      if (desc_req)
      begin
        desc_hit_ff <= (src != HPS_SRC_NONE);
        desc_len_ff <= str_len;
        desc_data_ff <= desc_mux;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      port_usb3_enable_ff <= 4'h0;
      port_usb2_enable_ff <= 4'h0;
    end
    else if (clk_en)
    begin
      port_usb3_enable_ff <= nxt_usb3;
      port_usb2_enable_ff <= nxt_usb2;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rd_valid = reg_rd_valid_ff;
  assign desc_ack = desc_ack_ff;
  assign desc_hit = desc_hit_ff;
  assign desc_len = desc_len_ff;
  assign desc_data = desc_data_ff;
  assign port_usb3_enable = port_usb3_enable_ff;
  assign port_usb2_enable = port_usb2_enable_ff;
endmodule

// [sim/hps_regs_sva.sv]
// Port assertions for the hub string registers
`timescale 1ns/100ps
module hps_regs_sva
  import hps_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic desc_req,
  input wire logic [7:0] desc_index,
  input wire logic [6:0] maker_string_length,
  input wire logic [6:0] product_text_length,
  input wire logic desc_ack,
  input wire logic desc_hit,
  input wire logic [6:0] desc_len,
  input wire logic [7:0] desc_data,
  input wire logic [3:0] port_available,
  input wire logic [3:0] port_usb3_enable,
  input wire logic [3:0] port_usb2_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic dq = clk_en && desc_req;
  wire logic [6:0] ml = maker_string_length;
  wire logic [6:0] pl = product_text_length;
  rsvd_zero_a: assert property (
    clk_en && reg_rd && reg_addr == HPS_OFS_RESTRICT
    |=> reg_rdata[7:4] == 4'h0) else $error("reserved bits set");
  usb2_keep_a: assert property (
    $past(clk_en && !reset) |-> (($past(port_available) & ~port_usb2_enable)
    | (port_usb3_enable & ~$past(port_available))) == 4'h0)
    else $error("port enable wrong");
  usb3_sub_a: assert property (
    (port_usb3_enable & ~port_usb2_enable) == 4'h0) else $error("usb3 alone");
  serial_answer_a: assert property (
    dq && desc_index == HPS_IDX_SERIAL
    |=> desc_ack && desc_hit && desc_len == HPS_SERIAL_LEN)
    else $error("serial answer");
  maker_answer_a: assert property (
    dq && desc_index == HPS_IDX_MAKER && ml != 0 && ml <= HPS_MAX_LEN
    |=> desc_ack && desc_hit && desc_len == $past(ml))
    else $error("maker answer");
  product_answer_a: assert property (
    dq && desc_index == HPS_IDX_PRODUCT && pl != 0 && pl <= HPS_MAX_LEN
    |=> desc_hit && desc_len == $past(pl))
    else $error("product answer");
  no_string_a: assert property (
    dq && desc_index == HPS_IDX_PRODUCT && pl == 0
    |=> !desc_hit && desc_len == 0 && desc_data == 8'h00)
    else $error("empty product");
  len_cap_a: assert property (
    dq && desc_index == HPS_IDX_MAKER && ml > HPS_MAX_LEN
    |=> desc_len == HPS_MAX_LEN) else $error("no cap");
endmodule
bind hps_regs hps_regs_sva chk
(
  .core_clk(core_clk),
  .reset(reset),
  .clk_en(clk_en),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .desc_req(desc_req),
  .desc_index(desc_index),
  .maker_string_length(maker_string_length),
  .product_text_length(product_text_length),
  .desc_ack(desc_ack),
  .desc_hit(desc_hit),
  .desc_len(desc_len),
  .desc_data(desc_data),
  .port_available(port_available),
  .port_usb3_enable(port_usb3_enable),
  .port_usb2_enable(port_usb2_enable)
);

// [sim/hps_usb_host.sv]
// Host model fetching one descriptor byte per go pulse
`timescale 1ns/100ps
module hps_usb_host
(
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] idx,
  input wire logic [6:0] pos,
  output logic desc_req = 1'b0,
  output logic [7:0] desc_index = 8'h00,
  output logic [6:0] desc_pos = 7'h00
);
  // Idle lines flip each cycle so a stale value never passes
  always @(posedge core_clk)
  begin
    desc_req <= #1 go;
    desc_index <= #1 go ? idx : ~desc_index;
    desc_pos <= #1 go ? pos : ~desc_pos;
  end
endmodule

// [sim/test_hps_regs.sv]
// Self-checking bench for the hub string registers
`timescale 1ns/100ps
module test_hps_regs
  import hps_pkg::*;
();
  localparam logic [7:0] SDEF = 8'h5A; // Arbitrary value
  logic core_clk, reset, reg_wr, reg_rd, go, desc_req, desc_ack;
  logic removable_override_enable, custom_serial_enable;
  logic custom_strings_enable, reg_rd_valid, desc_hit;
  logic clk_en = 1'b1;
  logic [6:0] maker_string_length, product_text_length, pos, desc_pos;
  logic [6:0] desc_len;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, idx, desc_index, desc_data;
  logic [3:0] port_available, port_usb3_enable, port_usb2_enable;
  int fail_count, check_count, n;
  hps_usb_host host
  (
    .core_clk(core_clk),
    .go(go),
    .idx(idx),
    .pos(pos),
    .desc_req(desc_req),
    .desc_index(desc_index),
    .desc_pos(desc_pos)
  );
  hps_regs #(.SERIAL_DEFAULT(SDEF)) dut
  (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .removable_override_enable(removable_override_enable),
    .custom_serial_enable(custom_serial_enable),
    .custom_strings_enable(custom_strings_enable),
    .maker_string_length(maker_string_length),
    .product_text_length(product_text_length),
    .port_available(port_available),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .desc_req(desc_req),
    .desc_index(desc_index),
    .desc_pos(desc_pos),
    .desc_ack(desc_ack),
    .desc_hit(desc_hit),
    .desc_len(desc_len),
    .desc_data(desc_data),
    .port_usb3_enable(port_usb3_enable),
    .port_usb2_enable(port_usb2_enable)
  );
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // ************
  // Bench tasks
  // ************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic hang;
    fail_count++;
    summarize;
  endtask
  // Each access leaves one idle cycle so no strobe is set twice at once
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick;
    reg_wr = 0;
    tick;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1;
    reg_addr = a;
    tick;
    reg_rd = 0;
    if (reg_rd_valid !== 1'b1)
      hang;
    chk(reg_rdata, e);
    tick;
  endtask
  task automatic desc(input logic [7:0] i, input logic [6:0] p,
                      input logic [7:0] hl, input logic [7:0] d);
    go = 1;
    idx = i;
    pos = p;
    tick;
    go = 0;
    for (n = 0; n < 4 && desc_ack !== 1'b1; n++)
      tick;
    if (n == 4)
      hang;
    chk({desc_hit, desc_len}, hl);
    chk(desc_data, d);
    tick;
  endtask
  initial
  begin
    {reset, reg_wr, reg_rd, go, removable_override_enable} = 5'h10;
    {custom_serial_enable, custom_strings_enable} = 2'b00;
    {maker_string_length, product_text_length, pos} = '0;
    {reg_addr, reg_wdata, idx, port_available} = '0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk);
    #1 reset = 0;
    rreg(8'h26, 8'h00);
    rreg(8'h50, 8'h00);
    rreg(8'hCF, 8'h00);
    rreg(8'h30, SDEF);
    rreg(8'hF0, 8'h00);
    $display("reset test done");
    wreg(8'h26, 8'hFF);
    rreg(8'h26, 8'h00);
    removable_override_enable = 1;
    wreg(8'h26, 8'hFF);
    rreg(8'h26, 8'h0F);
    port_available = 4'hF;
    tick;
    chk({port_usb3_enable, port_usb2_enable}, 8'h0F);
    wreg(8'h26, 8'h05);
    port_available = 4'hA;
    tick;
    chk({port_usb3_enable, port_usb2_enable}, 8'hAF);
    $display("restriction test done");
    wreg(8'h4F, 8'h11);
    rreg(8'h4F, SDEF);
    custom_serial_enable = 1;
    wreg(8'h4F, 8'h11);
    desc(8'h01, 7'h1F, 8'hA0, 8'h11);
    $display("serial test done");
    custom_strings_enable = 1;
    wreg(8'h50, 8'h48);
    wreg(8'h90, 8'h41);
    wreg(8'h91, 8'h00);
    maker_string_length = 7'h02;
    desc(8'h03, 7'h00, 8'h82, 8'h48);
    desc(8'h03, 7'h02, 8'h82, 8'h00);
    maker_string_length = 7'h64;
    desc(8'h03, 7'h00, 8'hC0, 8'h48);
    desc(8'h02, 7'h00, 8'h00, 8'h00);
    product_text_length = 7'h02;
    desc(8'h02, 7'h00, 8'h82, 8'h41);
    desc(8'h04, 7'h00, 8'h00, 8'h00);
    custom_strings_enable = 0;
    wreg(8'h90, 8'h77);
    rreg(8'h90, 8'h41);
    $display("string test done");
    // Frozen clock enable must drop an otherwise allowed write
    custom_strings_enable = 1;
    clk_en = 0;
    wreg(8'h50, 8'h99);
    clk_en = 1;
    rreg(8'h50, 8'h48);
    // Mid-run reset must return everything written so far to its reset value
    reset = 1;
    tick;
    reset = 0;
    rreg(8'h50, 8'h00);
    rreg(8'h90, 8'h00);
    rreg(8'h4F, SDEF);
    rreg(8'h26, 8'h00);
    chk({port_usb3_enable, port_usb2_enable}, 8'hAA);
    $display("freeze and reset test done");
    summarize;
  end
endmodule
